// ---- common/swf_pkg.sv ----
// package: constants and carrier types for the serial/watchdog/fail-safe block
package swf_pkg;

  // ---------------------------------------------------------------------------
  // clock, timing and width constants
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned FS_FILT_MIN_NS   = 1000;
  localparam int unsigned FS_FILT_MAX_NS   = 3000;
  localparam int unsigned FS_FILT_CYC      = (FS_FILT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SEL_TMO_MS       = 35;
  localparam int unsigned SEL_TMO_CYC      = SEL_TMO_MS * CLK_MHZ * 1000;
  localparam int unsigned LONG_OPEN_MS     = 70;
  localparam int unsigned LONG_OPEN_CYC    = LONG_OPEN_MS * CLK_MHZ * 1000;
  localparam int unsigned CLOSED_MS        = 15;
  localparam int unsigned CLOSED_CYC       = CLOSED_MS * CLK_MHZ * 1000;
  localparam int unsigned PERIOD_MS        = 43;
  localparam int unsigned PERIOD_CYC       = PERIOD_MS * CLK_MHZ * 1000;
  localparam int unsigned FRAME_BITS       = 24;
  localparam int unsigned CNT_W            = 32;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic RST_OUTPUTS_ENABLE = 1'h0;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {WD_LONG_OPEN, WD_CLOSED, WD_OPEN} swf_wd_type;

  typedef struct packed {
    logic sclk;
    logic sel_n;
    logic mosi;
  } swf_spi_in_type;

  typedef struct packed {
    logic miso;
    logic miso_oe;
  } swf_spi_out_type;

endpackage

// ---- dv/swf_host_model.sv ----
// partner model: serial host that drives clock polarity 0, phase 0 frames
`timescale 1ns/100ps
`default_nettype none
module swf_host_model #(
  parameter int unsigned FRAME_BITS = 24,
  parameter int unsigned GAP_CYC    = 600
) (
  input  wire logic                     clk,
  output var  swf_pkg::swf_spi_in_type  spi_in,
  input  wire swf_pkg::swf_spi_out_type spi_out
);
  // ---------------------------------------------------------------------------
  // host tasks; every change lands on the falling clk edge
  // ---------------------------------------------------------------------------
  // idle: select high, serial clock low
  initial spi_in = '{sclk: 1'h0, sel_n: 1'h1, mosi: 1'h0};

  // move select alone, so the bench can hold it low past the timeout
  task automatic set_sel(input logic lvl);
    @(negedge clk);
    spi_in.sel_n = lvl;
  endtask

  // one whole frame, msb first; gives back the reply and whether output stayed on
  task automatic frame(input  logic [FRAME_BITS-1:0] tx,
                       output logic [FRAME_BITS-1:0] rx,
                       output logic                  oe_all);
    rx = '0;
    oe_all = 1'h1;
    set_sel(1'h0);
    repeat (2) @(negedge clk);
    for (int i = FRAME_BITS - 1; i >= 0; i--)
    begin
      spi_in.mosi = tx[i];
      repeat (2) @(negedge clk);
      spi_in.sclk = 1'h1;
      rx[i] = spi_out.miso;
      oe_all = oe_all & spi_out.miso_oe;
      repeat (2) @(negedge clk);
      spi_in.sclk = 1'h0;
      spi_in.mosi = ~spi_in.mosi; // hold time over: no stale level left behind
    end
    repeat (2) @(negedge clk);
    spi_in.sel_n = 1'h1;
    repeat (GAP_CYC) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ---- dv/test_swf_core.sv ----
// testbench: frames, select timeout, watchdog windows, fail-safe filter, diag pin
`timescale 1ns/100ps
`default_nettype none
module test_swf_core;
  localparam int unsigned FB = 24;
  localparam int unsigned TMO = 200;
  localparam int unsigned CLS = 150;
  logic clk = 1'h0, arst_n = 1'h0;
  swf_pkg::swf_spi_in_type spi_in;
  swf_pkg::swf_spi_out_type spi_out;
  logic [FB-1:0] tx_word = 24'h000000, rx_word, rx;
  logic rx_valid, comm_error, wd_fault, oe_bit, fs_flag, fs_glob, gate_off, diag_n, diag_oe;
  logic wd_trigger = 1'h0, fs_n = 1'h1, oe_set = 1'h0, st_clr = 1'h0, tw = 1'h0, tw_msk = 1'h0;
  logic oe_all;
  int n_mismatch = 0, comparisons = 0, n_valid = 0;

  swf_core #(.FRAME_BITS(FB), .SEL_TMO_CYC(TMO), .LONG_OPEN_CYC(700), .CLOSED_CYC(CLS),
    .PERIOD_CYC(430)) dut_u (.clk(clk), .arst_n(arst_n), .spi_in(spi_in), .spi_out(spi_out),
    .tx_word(tx_word), .rx_word(rx_word), .rx_valid(rx_valid), .comm_error(comm_error),
    .wd_trigger(wd_trigger), .wd_fault(wd_fault), .failsafe_off_in_n(fs_n),
    .outputs_enable_set(oe_set), .outputs_enable_bit(oe_bit), .failsafe_status_flag(fs_flag),
    .failsafe_global_bit(fs_glob), .gate_force_off(gate_off), .status_clear(st_clr),
    .thermal_warn(tw), .diag_thermal_warn_mask(tw_msk), .diag_out_n(diag_n),
    .diag_out_oe(diag_oe));
  swf_host_model #(.FRAME_BITS(FB), .GAP_CYC(600)) host_u (.clk(clk), .spi_in(spi_in),
    .spi_out(spi_out));

  // ---------------------------------------------------------------------------
  // clock, pulse counter, compare helpers
  // ---------------------------------------------------------------------------
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (rx_valid === 1'h1) n_valid <= n_valid + 1;
  task automatic chk_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [FB-1:0] e, input logic [FB-1:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic pulse(ref logic s, input int unsigned wait_cyc);
    repeat (wait_cyc) @(negedge clk);
    s = 1'h1;
    @(negedge clk);
    s = 1'h0;
    @(negedge clk);
  endtask
  task automatic close_out;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_watchdog;
    pulse(wd_trigger, 100);
    chk_bit("wd_fault long open", 1'h0, wd_fault);
    pulse(wd_trigger, CLS + 40);
    chk_bit("wd_fault safe", 1'h0, wd_fault);
    pulse(wd_trigger, 50);
    chk_bit("wd_fault early", 1'h1, wd_fault);
    pulse(st_clr, 0);
    chk_bit("wd_fault clear", 1'h0, wd_fault);
    repeat (700) @(negedge clk);
    chk_bit("wd_fault late", 1'h1, wd_fault);
    pulse(st_clr, 0);
  endtask
  task automatic t_frames(input logic [FB-1:0] a, input logic [FB-1:0] b);
    int v0;
    v0 = n_valid;
    tx_word = a;
    host_u.frame(b, rx, oe_all);
    chk_word("reply", a, rx);
    chk_bit("miso_oe in frame", 1'h1, oe_all);
    chk_bit("miso_oe idle", 1'h0, spi_out.miso_oe);
    chk_word("rx_word", b, rx_word);
    chk_bit("rx_valid once", 1'h1, n_valid == v0 + 1);
  endtask
  task automatic t_timeout;
    int v0;
    v0 = n_valid;
    host_u.set_sel(1'h0);
    repeat (TMO - 10) @(negedge clk);
    chk_bit("comm_error early", 1'h0, comm_error);
    repeat (20) @(negedge clk);
    chk_bit("comm_error", 1'h1, comm_error);
    host_u.set_sel(1'h1);
    repeat (10) @(negedge clk);
    chk_bit("no commit", 1'h1, n_valid == v0);
    pulse(st_clr, 0);
  endtask
  task automatic t_failsafe;
    pulse(oe_set, 0);
    chk_bit("oe bit set", 1'h1, oe_bit);
    fs_n = 1'h0;
    repeat (swf_pkg::FS_FILT_CYC - 20) @(negedge clk);
    fs_n = 1'h1;
    @(negedge clk);
    chk_bit("fs short glitch", 1'h0, fs_flag);
    fs_n = 1'h0;
    repeat (swf_pkg::FS_FILT_CYC + 5) @(negedge clk);
    chk_bit("gate_force_off", 1'h1, gate_off);
    chk_bit("fs status", 1'h1, fs_flag);
    chk_bit("fs global", 1'h1, fs_glob);
    chk_bit("oe bit cleared", 1'h0, oe_bit);
    fs_n = 1'h1;
  endtask
  task automatic t_diag;
    for (int i = 0; i < 4; i++)
    begin
      tw = i[0];
      tw_msk = i[1];
      repeat (3) @(negedge clk);
      chk_bit("diag_out_oe", i == 3, diag_oe);
      chk_bit("diag_out_n", i != 3, diag_n);
    end
  endtask
  task automatic t_long_open;
    arst_n = 1'h0;
    repeat (3) @(negedge clk);
    chk_bit("fs status reset", 1'h0, fs_flag);
    chk_bit("wd_fault reset", 1'h0, wd_fault);
    arst_n = 1'h1;
    repeat (690) @(negedge clk);
    chk_bit("wd_fault in long open", 1'h0, wd_fault);
    repeat (20) @(negedge clk);
    chk_bit("wd_fault long open expiry", 1'h1, wd_fault);
  endtask

  initial
  begin
    repeat (20) @(negedge clk);
    arst_n = 1'h1;
    @(negedge clk);
    t_watchdog;
    t_frames(24'ha5c301, 24'h3c96e7);
    t_frames(24'h800001, 24'h7ffffe);
    t_timeout;
    t_failsafe;
    t_diag;
    t_long_open;
    close_out;
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    n_mismatch++;
    close_out;
  end
endmodule
`default_nettype wire

// ---- rtl/swf_core.sv ----
// module: serial slave, window watchdog and fail-safe input filter
`timescale 1ns/100ps
`default_nettype none

module swf_core #(
  parameter int unsigned FRAME_BITS    = swf_pkg::FRAME_BITS,
  parameter int unsigned SEL_TMO_CYC   = swf_pkg::SEL_TMO_CYC,
  parameter int unsigned LONG_OPEN_CYC = swf_pkg::LONG_OPEN_CYC,
  parameter int unsigned CLOSED_CYC    = swf_pkg::CLOSED_CYC,
  parameter int unsigned PERIOD_CYC    = swf_pkg::PERIOD_CYC
) (
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire swf_pkg::swf_spi_in_type spi_in,
  output var  swf_pkg::swf_spi_out_type spi_out,
  input  wire logic [FRAME_BITS-1:0]   tx_word,
  output logic [FRAME_BITS-1:0]        rx_word,
  output logic                         rx_valid,
  output logic                         comm_error,
  input  wire logic                    wd_trigger,
  output logic                         wd_fault,
  input  wire logic                    failsafe_off_in_n,
  input  wire logic                    outputs_enable_set,
  output logic                         outputs_enable_bit,
  output logic                         failsafe_status_flag,
  output logic                         failsafe_global_bit,
  output logic                         gate_force_off,
  input  wire logic                    status_clear,
  input  wire logic                    thermal_warn,
  input  wire logic                    diag_thermal_warn_mask,
  output logic                         diag_out_n,
  output logic                         diag_out_oe
);

  // refuse parameter values the counters cannot serve
  if (FRAME_BITS < 2 || CLOSED_CYC < 2 || CLOSED_CYC >= PERIOD_CYC || SEL_TMO_CYC < 2
      || LONG_OPEN_CYC < 2)
  begin : g_param_check
    $error("swf_core: unsupported parameter values");
  end

  typedef struct packed {
    logic                    sclk_d;
    logic                    sel_d;
    logic [FRAME_BITS-1:0]   shin;
    logic [FRAME_BITS-1:0]   shout;
    logic [swf_pkg::CNT_W-1:0] sel_cnt;
    logic                    tmo;
    logic                    miso;
    logic                    miso_oe;
    logic [FRAME_BITS-1:0]   rx_word;
    logic                    rx_valid;
    logic                    comm_error;
    swf_pkg::swf_wd_type     wd_state;
    logic [swf_pkg::CNT_W-1:0] wd_cnt;
    logic                    wd_fault;
    logic [7:0]              fs_cnt;
    logic                    fs_status;
    logic                    fs_global;
    logic                    oe_bit;
    logic                    force_off;
    logic                    diag_n;
    logic                    diag_oe;
  } swf_state_type;

  swf_state_type st;
  swf_state_type next_st;

  // ---------------------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------------------
  always_comb
  begin
    logic rise;
    logic fall;
    logic fs_hit;
    rise    = 1'b0;
    fall    = 1'b0;
    fs_hit  = 1'b0;
    next_st = st;
    next_st.sclk_d   = spi_in.sclk;
    next_st.sel_d    = spi_in.sel_n;
    next_st.rx_valid = 1'b0;

    // software clears flags first, so a hardware set below wins
    if (status_clear)
    begin
      next_st.fs_status  = 1'b0;
      next_st.fs_global  = 1'b0;
      next_st.comm_error = 1'b0;
      next_st.wd_fault   = 1'b0;
    end
    rise = spi_in.sclk & ~st.sclk_d & ~spi_in.sel_n;
    fall = ~spi_in.sclk & st.sclk_d & ~spi_in.sel_n;

    // frame start: load reply and enable output
    if (!spi_in.sel_n && st.sel_d)
    begin
      next_st.shout   = tx_word;
      next_st.miso    = tx_word[FRAME_BITS-1];
      next_st.sel_cnt = '0;
      next_st.tmo     = 1'b0;
    end
    next_st.miso_oe = ~spi_in.sel_n;
    if (rise)
      next_st.shin = {st.shin[FRAME_BITS-2:0], spi_in.mosi};
    if (fall)
    begin
      next_st.shout = {st.shout[FRAME_BITS-2:0], 1'b0};
      next_st.miso  = st.shout[FRAME_BITS-2];
    end

    // select-low timeout counter
    if (!spi_in.sel_n && !(st.sel_d))
    begin
      if (st.sel_cnt >= swf_pkg::CNT_W'(SEL_TMO_CYC - 1))
      begin
        next_st.tmo        = 1'b1;
        next_st.comm_error = 1'b1;
      end
      else
        next_st.sel_cnt = st.sel_cnt + 1'b1;
    end

    // frame end: commit unless timed out
    if (spi_in.sel_n && !st.sel_d)
    begin
      if (st.tmo)
        next_st.comm_error = 1'b1;
      else
      begin
        next_st.rx_word  = st.shin;
        next_st.rx_valid = 1'b1;
      end
    end

    // window watchdog
    unique case (st.wd_state)
      swf_pkg::WD_LONG_OPEN:
      begin
        next_st.wd_cnt = st.wd_cnt + 1'b1;
        if (wd_trigger)
        begin
          next_st.wd_state = swf_pkg::WD_CLOSED;
          next_st.wd_cnt   = '0;
        end
        else if (st.wd_cnt >= swf_pkg::CNT_W'(LONG_OPEN_CYC - 1))
        begin
          next_st.wd_fault = 1'b1;
          next_st.wd_cnt   = '0;
        end
      end
      swf_pkg::WD_CLOSED:
      begin
        next_st.wd_cnt = st.wd_cnt + 1'b1;
        if (wd_trigger)
        begin
          next_st.wd_fault = 1'b1;
          next_st.wd_cnt   = '0;
        end
        else if (st.wd_cnt >= swf_pkg::CNT_W'(CLOSED_CYC - 1))
          next_st.wd_state = swf_pkg::WD_OPEN;
      end
      swf_pkg::WD_OPEN:
      begin
        next_st.wd_cnt = st.wd_cnt + 1'b1;
        if (wd_trigger)
        begin
          next_st.wd_state = swf_pkg::WD_CLOSED;
          next_st.wd_cnt   = '0;
        end
        else if (st.wd_cnt >= swf_pkg::CNT_W'(PERIOD_CYC - 1))
        begin
          next_st.wd_fault = 1'b1;
          next_st.wd_state = swf_pkg::WD_CLOSED;
          next_st.wd_cnt   = '0;
        end
      end
      default:
        next_st.wd_state = swf_pkg::WD_LONG_OPEN;
    endcase

    // fail-safe filter: low must persist for the filter time
    if (failsafe_off_in_n)
      next_st.fs_cnt = '0;
    else if (st.fs_cnt < 8'(swf_pkg::FS_FILT_CYC))
      next_st.fs_cnt = st.fs_cnt + 1'b1;
    fs_hit = (st.fs_cnt == 8'(swf_pkg::FS_FILT_CYC));
    next_st.force_off = fs_hit;

    // output enable: set by request, fail-safe clear wins
    if (outputs_enable_set)
      next_st.oe_bit = 1'b1;
    if (fs_hit)
    begin
      next_st.fs_status = 1'b1;
      next_st.fs_global = 1'b1;
      next_st.oe_bit    = 1'b0;
    end
    next_st.diag_n  = ~(thermal_warn & diag_thermal_warn_mask);
    next_st.diag_oe = thermal_warn & diag_thermal_warn_mask;
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st          <= '0;
      st.sel_d    <= 1'b1;
      st.diag_n   <= 1'b1;
      st.oe_bit   <= swf_pkg::RST_OUTPUTS_ENABLE;
      st.wd_state <= swf_pkg::WD_LONG_OPEN;
    end
    else
      st <= next_st;
  end

  // outputs straight from flip-flops
  assign spi_out.miso         = st.miso;
  assign spi_out.miso_oe      = st.miso_oe;
  assign rx_word              = st.rx_word;
  assign rx_valid             = st.rx_valid;
  assign comm_error           = st.comm_error;
  assign wd_fault             = st.wd_fault;
  assign outputs_enable_bit   = st.oe_bit;
  assign failsafe_status_flag = st.fs_status;
  assign failsafe_global_bit  = st.fs_global;
  assign gate_force_off       = st.force_off;
  assign diag_out_n           = st.diag_n;
  assign diag_out_oe          = st.diag_oe;                             // open drain pull

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  a_miso_tristate: assert property (@(posedge clk) disable iff (!arst_n)
    $past(spi_in.sel_n) |-> !spi_out.miso_oe)
    else $error("data output driven while select high");
  a_fs_filter: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(failsafe_status_flag) |-> $past(!failsafe_off_in_n, 2))
    else $error("fail-safe flagged without low input");
  a_fs_action: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(gate_force_off) |-> !outputs_enable_bit && failsafe_global_bit)
    else $error("fail-safe did not clear output enable");
  a_diag_mask: assert property (@(posedge clk) disable iff (!arst_n)
    diag_out_oe |-> $past(thermal_warn && diag_thermal_warn_mask))
    else $error("diagnostic pulled low without masked event");
  a_early_trig: assert property (@(posedge clk) disable iff (!arst_n)
    st.wd_state == swf_pkg::WD_CLOSED && wd_trigger |=> wd_fault)
    else $error("early trigger not faulted");
  a_tmo_drop: assert property (@(posedge clk) disable iff (!arst_n)
    st.tmo && spi_in.sel_n && !st.sel_d |=> !rx_valid && comm_error)
    else $error("timed-out frame committed");
  a_tmo_set: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(st.tmo) |-> $past(st.sel_cnt) == swf_pkg::CNT_W'(SEL_TMO_CYC - 1))
    else $error("select timeout at wrong count");
  a_sample_rise: assert property (@(posedge clk) disable iff (!arst_n)
    spi_in.sclk && !st.sclk_d && !spi_in.sel_n |=> st.shin[0] == $past(spi_in.mosi))
    else $error("input bit not sampled on rising clock");
  a_wd_open: assert property (@(posedge clk) disable iff (!arst_n)
    st.wd_state == swf_pkg::WD_LONG_OPEN && wd_trigger |=> !wd_fault || $past(wd_fault))
    else $error("long open window refused trigger");

  c_frame: cover property (@(posedge clk) disable iff (!arst_n) rx_valid);
  c_fs: cover property (@(posedge clk) disable iff (!arst_n) $rose(failsafe_status_flag));
  c_wd_ok: cover property (@(posedge clk) disable iff (!arst_n)
    st.wd_state == swf_pkg::WD_OPEN && wd_trigger);

endmodule
`default_nettype wire
